// ==== src/ejc_ja_fifo.sv ====
// Jitter attenuator bit FIFO with programmable depth, clear and re-centring.
// Assumes one write and one read strobe per bit from the line timing.
`timescale 1ns/1ns
module ejc_ja_fifo
  import ejc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  ejc_ja_if.fifo ja,
  input wire logic wr_valid,
  input wire logic wr_bit,
  input wire logic rd_valid,
  output logic rd_bit_q
);
  // ==========================================================
  // Storage and pointers
  logic mem [EJC_FIFO_WORDS];
  logic [6:0] wp_q, rp_q;
  logic [7:0] cnt_q, cnt_d, limit, half;
  logic [4:0] ctr_q;
  logic do_wr, do_rd;

  // Depth code 0..7 maps to 16..128 words
  assign limit = ({5'h00, ja.depth} + 8'h01) * EJC_DEPTH_UNIT;
  assign half = {1'b0, limit[7:1]};
  assign do_wr = wr_valid && ja.enable && (cnt_q < limit) && !ja.clear;
  assign do_rd = rd_valid && ja.enable && (cnt_q != 8'h00) && !ja.clear;
  assign cnt_d = cnt_q + {7'h00, do_wr} - {7'h00, do_rd};
  assign ja.empty = (cnt_q == 8'h00);
  assign ja.full = (cnt_q >= limit);
  assign ja.level = cnt_q;
  assign ja.centring = (ctr_q != 5'h00);

  // Data words are never erased; only pointers move
  always_ff @(posedge clk) begin
    if (do_wr) begin
      mem[wp_q] <= wr_bit;
    end
  end

  // Pointer control; clear wins, then re-centre, then traffic
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wp_q <= 7'h00;
      rp_q <= 7'h00;
      cnt_q <= 8'h00;
      rd_bit_q <= 1'b0;
    end else if (ja.clear) begin
      wp_q <= 7'h00;
      rp_q <= 7'h00;
      cnt_q <= 8'h00;
    end else if (ja.recentre) begin
      rp_q <= wp_q - half[6:0];
      cnt_q <= half;
    end else begin
      if (do_wr) begin
        wp_q <= wp_q + 7'h01;
      end
      if (do_rd) begin
        rp_q <= rp_q + 7'h01;
        rd_bit_q <= mem[rp_q];
      end
      cnt_q <= cnt_d;
    end
  end

  // Faster response window after a re-centre
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctr_q <= 5'h00;
    end else if (ja.recentre) begin
      ctr_q <= EJC_CENTRE_CNT;
    end else if (ctr_q != 5'h00) begin
      ctr_q <= ctr_q - 5'h01;
    end
  end
endmodule

// ==== src/ejc_ja_if.sv ====
// Carrier between the control registers and the attenuator FIFO.
// Assumes both ends share clk and rst_n.
`timescale 1ns/1ns
interface ejc_ja_if;
  logic enable;
  logic [2:0] depth;
  logic clear;
  logic recentre;
  logic empty;
  logic full;
  logic centring;
  logic [7:0] level;
  modport ctrl (output enable, output depth, output clear, output recentre,
                input empty, input full, input centring, input level);
  modport fifo (input enable, input depth, input clear, input recentre,
                output empty, output full, output centring, output level);
endinterface

// ==== src/ejc_pkg.sv ====
// Constants shared by the E1 access and jitter control block.
// Assumes a 50 MHz clock and the 5-bit paged register port of the device.
package ejc_pkg;
  // ==========================================================
  // Register map (page 02h)
  localparam logic [7:0] EJC_PAGE_CTRL = 8'h02;
  localparam logic [4:0] EJC_ADDR_ACCESS = 5'h13;
  localparam logic [4:0] EJC_ADDR_JA = 5'h18;
  localparam logic [7:0] EJC_ACCESS_RST = 8'h00;
  localparam logic [7:0] EJC_JA_RST = 8'h00;
  localparam logic [7:0] EJC_ACCESS_MASK = 8'h07;
  localparam logic [7:0] EJC_JA_MASK = 8'hFE;
  // ==========================================================
  // Field positions
  localparam int EJC_B_LOSSSEL = 2;
  localparam int EJC_B_SEQSEL = 1;
  localparam int EJC_B_FPFMT = 0;
  localparam int EJC_B_JAEN = 7;
  localparam int EJC_B_JAPATH = 6;
  localparam int EJC_B_JACTR = 5;
  localparam int EJC_B_DEPTH_LO = 2;
  localparam int EJC_B_JACLR = 1;
  // ==========================================================
  // Attenuator and sequence figures
  localparam logic [7:0] EJC_DEPTH_UNIT = 8'h10;
  localparam int EJC_FIFO_WORDS = 128;
  localparam logic [14:0] EJC_PRBS_SEED = 15'h7FFF;
  localparam int EJC_CLK_NS = 20;
  localparam int EJC_CENTRE_NS = 320;
  localparam int EJC_CENTRE_CYC = (EJC_CENTRE_NS + EJC_CLK_NS - 1) / EJC_CLK_NS;
  localparam logic [4:0] EJC_CENTRE_CNT = EJC_CENTRE_CYC[4:0];
endpackage

// ==== src/ejc_top.sv ====
// Access control and jitter attenuator control words of the E1 framer.
// Assumes a synchronous paged register port and status inputs in the clk domain.
`timescale 1ns/1ns
//
// Contract
// - Select one: loss output follows signal loss
// - Select zero: loss or frame loss
// - Sequence select one: A-law milliwatt pattern
// - Sequence select zero: 2^15-1 PRBS pattern
// - Writing sequence select one resets PRBS
// - Format bit picks GCI or ST-BUS pulse
// - Enable bit inserts or disables attenuator
// - Path bit: one transmit, zero receive
// - Centre toggle re-centres read pointer, faster response
module ejc_top
  import ejc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] reg_page,
  input wire logic [4:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata_q,
  input wire logic signal_loss_flag,
  input wire logic frame_sync,
  output logic loss_indicator_output_q,
  output logic frame_pulse_format_q,
  input wire logic seq_step,
  input wire logic tx_slot_test_enable,
  input wire logic rx_slot_test_enable,
  input wire logic [7:0] tx_pcm,
  input wire logic [7:0] rx_pcm,
  output logic [7:0] tx_pcm_q,
  output logic [7:0] rx_pcm_q,
  output logic ja_on_tx_q,
  output logic ja_on_rx_q,
  input wire logic ja_wr_valid,
  input wire logic ja_wr_bit,
  input wire logic ja_rd_valid,
  output logic ja_rd_bit_q,
  output logic ja_empty_q,
  output logic ja_centring_q
);
  // ==========================================================
  // Register decode
  logic [7:0] acc_q, ja_q, acc_d, ja_d;
  logic sel_acc, sel_ja, wr_acc, wr_ja, ctr_pulse_q;
  logic [7:0] rd_mux;
  ejc_ja_if jif ();

  function automatic logic hit(input logic [7:0] pg, input logic [4:0] ad,
                               input logic [4:0] want);
    hit = (pg == EJC_PAGE_CTRL) && (ad == want);
  endfunction

  assign sel_acc = hit(reg_page, reg_addr, EJC_ADDR_ACCESS);
  assign sel_ja = hit(reg_page, reg_addr, EJC_ADDR_JA);
  assign wr_acc = reg_wr && sel_acc;
  assign wr_ja = reg_wr && sel_ja;
  assign acc_d = wr_acc ? (reg_wdata & EJC_ACCESS_MASK) : acc_q;
  assign ja_d = wr_ja ? (reg_wdata & EJC_JA_MASK) : ja_q;
  // Unmapped addresses read zero
  assign rd_mux = sel_acc ? acc_q : (sel_ja ? ja_q : 8'h00);

  // Control words
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      acc_q <= EJC_ACCESS_RST;
      ja_q <= EJC_JA_RST;
    end else begin
      acc_q <= acc_d;
      ja_q <= ja_d;
    end
  end

  // Read data, registered
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata_q <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata_q <= rd_mux;
    end
  end

  // ==========================================================
  // Loss indicator and frame pulse format
  logic loss_d;
  assign loss_d = acc_q[EJC_B_LOSSSEL] ? signal_loss_flag
                : (signal_loss_flag || !frame_sync);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      loss_indicator_output_q <= 1'b0;
      frame_pulse_format_q <= 1'b0;
    end else begin
      loss_indicator_output_q <= loss_d;
      frame_pulse_format_q <= acc_q[EJC_B_FPFMT];
    end
  end

  // ==========================================================
  // Test sequences
  logic [14:0] lfsr_q;
  logic [2:0] mw_idx_q;
  logic [7:0] prbs_byte, mw_byte, pattern;
  logic prbs_reset;

  // Eight steps of x^15 + x^14 + 1 per byte slot
  function automatic logic [22:0] prbs8(input logic [14:0] s);
    logic [14:0] t;
    logic [7:0] b;
    t = s;
    b = 8'h00;
    for (int i = 0; i < 8; i++) begin
      b = {b[6:0], t[14]};
      t = {t[13:0], t[14] ^ t[13]};
    end
    prbs8 = {t, b};
  endfunction

  // A-law digital milliwatt, eight-byte cycle
  function automatic logic [7:0] mw_lut(input logic [2:0] i);
    case (i)
      3'h0, 3'h3: mw_lut = 8'h34;
      3'h1, 3'h2: mw_lut = 8'h21;
      3'h4, 3'h7: mw_lut = 8'hB4;
      3'h5, 3'h6: mw_lut = 8'hA1;
      default: mw_lut = 8'h00;
    endcase
  endfunction

  logic [22:0] prbs_nx;
  assign prbs_nx = prbs8(lfsr_q);
  assign prbs_byte = prbs_nx[7:0];
  assign mw_byte = mw_lut(mw_idx_q);
  assign prbs_reset = wr_acc && reg_wdata[EJC_B_SEQSEL];
  assign pattern = acc_q[EJC_B_SEQSEL] ? mw_byte : prbs_byte;

  // Generator state; a reset write beats a step in the same cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lfsr_q <= EJC_PRBS_SEED;
      mw_idx_q <= 3'h0;
    end else if (prbs_reset) begin
      lfsr_q <= EJC_PRBS_SEED;
      mw_idx_q <= 3'h0;
    end else if (seq_step) begin
      lfsr_q <= prbs_nx[22:8];
      mw_idx_q <= mw_idx_q + 3'h1;
    end
  end

  // Per-slot substitution on both directions
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_pcm_q <= 8'h00;
      rx_pcm_q <= 8'h00;
    end else begin
      tx_pcm_q <= tx_slot_test_enable ? pattern : tx_pcm;
      rx_pcm_q <= rx_slot_test_enable ? pattern : rx_pcm;
    end
  end

  // ==========================================================
  // Jitter attenuator control
  assign jif.enable = ja_q[EJC_B_JAEN];
  assign jif.depth = ja_q[EJC_B_DEPTH_LO +: 3];
  assign jif.clear = ja_q[EJC_B_JACLR];
  assign jif.recentre = ctr_pulse_q;

  // Any write that flips the centre bit pulses a re-centre once, whether or not it sets clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctr_pulse_q <= 1'b0;
      ja_on_tx_q <= 1'b0;
      ja_on_rx_q <= 1'b0;
      ja_empty_q <= 1'b1;
      ja_centring_q <= 1'b0;
    end else begin
      ctr_pulse_q <= wr_ja && (reg_wdata[EJC_B_JACTR] != ja_q[EJC_B_JACTR]);
      ja_on_tx_q <= ja_q[EJC_B_JAEN] && ja_q[EJC_B_JAPATH];
      ja_on_rx_q <= ja_q[EJC_B_JAEN] && !ja_q[EJC_B_JAPATH];
      ja_empty_q <= jif.empty;
      ja_centring_q <= jif.centring;
    end
  end

  ejc_ja_fifo u_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .ja(jif.fifo),
    .wr_valid(ja_wr_valid),
    .wr_bit(ja_wr_bit),
    .rd_valid(ja_rd_valid),
    .rd_bit_q(ja_rd_bit_q)
  );

  // ==========================================================
  // Assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_loss_sel_one: assert property (acc_q[EJC_B_LOSSSEL] |=>
    loss_indicator_output_q == $past(signal_loss_flag))
    else $error("loss output not following signal loss");
  a_loss_sel_zero: assert property (!acc_q[EJC_B_LOSSSEL] |=>
    loss_indicator_output_q == ($past(signal_loss_flag) || !$past(frame_sync)))
    else $error("loss output not loss or frame loss");
  a_mw_pattern: assert property (acc_q[EJC_B_SEQSEL] && tx_slot_test_enable |=>
    tx_pcm_q == mw_lut($past(mw_idx_q)))
    else $error("milliwatt pattern missing");
  a_prbs_pattern: assert property (!acc_q[EJC_B_SEQSEL] && rx_slot_test_enable |=>
    rx_pcm_q == $past(prbs_byte))
    else $error("prbs pattern missing");
  a_prbs_reseed: assert property (wr_acc && reg_wdata[EJC_B_SEQSEL] |=>
    lfsr_q == EJC_PRBS_SEED && mw_idx_q == 3'h0)
    else $error("prbs not reset on select write");
  a_fp_format: assert property (wr_acc |=> ##1
    frame_pulse_format_q == $past(reg_wdata[EJC_B_FPFMT], 2))
    else $error("frame pulse format not applied");
  a_ja_disabled: assert property (!ja_q[EJC_B_JAEN] |=> !ja_on_tx_q && !ja_on_rx_q)
    else $error("attenuator active while disabled");
  a_ja_path: assert property (ja_q[EJC_B_JAEN] |=>
    ja_on_tx_q == $past(ja_q[EJC_B_JAPATH]) && ja_on_rx_q != ja_on_tx_q)
    else $error("attenuator path wrong");
  a_centre_window: assert property ($rose(ctr_pulse_q) |=> ##1
    ja_centring_q [*8])
    else $error("centring window too short");
  a_clear_empty: assert property (ja_q[EJC_B_JACLR] |=> ##1 ja_empty_q)
    else $error("fifo not empty under clear");
  // Level may sit above a freshly lowered depth, so check that it never grows there
  a_depth_cap: assert property (jif.level >=
    ({5'h00, jif.depth} + 8'h01) * EJC_DEPTH_UNIT |=> jif.level <= $past(jif.level))
    else $error("fifo grew past depth");
  a_unused_zero: assert property (reg_rd |=>
    (reg_rdata_q & ~($past(sel_acc) ? EJC_ACCESS_MASK
                   : ($past(sel_ja) ? EJC_JA_MASK : 8'h00))) == 8'h00)
    else $error("unused bit read as one");

  c_loss_frame: cover property (!acc_q[EJC_B_LOSSSEL] && !frame_sync ##1 loss_indicator_output_q);
  c_recentre: cover property (ctr_pulse_q ##2 ja_centring_q);
  c_fifo_full: cover property (ja_q[EJC_B_JAEN] && jif.full);
  c_mw_slot: cover property (acc_q[EJC_B_SEQSEL] && tx_slot_test_enable);
endmodule

// ==== tb/ejc_top_tb_top.sv ====
// Self-checking bench for the access and jitter attenuator control words.
// Assumes ejc_top alone, its register port and status inputs driven here.
`timescale 1ns/1ns
module ejc_top_tb_top
  import ejc_pkg::*;
;
  // ==========================================================
  // Stimulus and observed signals
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_page = 8'h02;
  logic [4:0] reg_addr = 5'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic signal_loss_flag = 1'b0;
  logic frame_sync = 1'b1;
  logic seq_step = 1'b0;
  logic tx_slot_test_enable = 1'b0;
  logic rx_slot_test_enable = 1'b0;
  logic [7:0] tx_pcm = 8'h5A;
  logic [7:0] rx_pcm = 8'hC3;
  logic ja_wr_valid = 1'b0;
  logic ja_wr_bit = 1'b0;
  logic ja_rd_valid = 1'b0;
  logic [7:0] reg_rdata_q, tx_pcm_q, rx_pcm_q;
  logic loss_indicator_output_q, frame_pulse_format_q, ja_on_tx_q, ja_on_rx_q;
  logic ja_rd_bit_q, ja_empty_q, ja_centring_q;
  int bad_count = 0;
  int n_checks = 0;
  logic [7:0] mw [8] = '{8'h34, 8'h21, 8'h21, 8'h34, 8'hB4, 8'hA1, 8'hA1, 8'hB4};

  ejc_top dut_u (.clk, .rst_n, .reg_page, .reg_addr, .reg_wr, .reg_rd, .reg_wdata,
    .reg_rdata_q, .signal_loss_flag, .frame_sync, .loss_indicator_output_q,
    .frame_pulse_format_q, .seq_step, .tx_slot_test_enable, .rx_slot_test_enable,
    .tx_pcm, .rx_pcm, .tx_pcm_q, .rx_pcm_q, .ja_on_tx_q, .ja_on_rx_q, .ja_wr_valid,
    .ja_wr_bit, .ja_rd_valid, .ja_rd_bit_q, .ja_empty_q, .ja_centring_q);

  // 50 MHz clock
  always #10 clk = ~clk;

  // ==========================================================
  // Access tasks
  task automatic chk(string nm, logic [7:0] seen, logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Sample at the falling edge so registered outputs have landed
  task automatic settle(int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic wr(logic [4:0] a, logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd_chk(string nm, logic [4:0] a, logic [7:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    chk(nm, reg_rdata_q, exp);
  endtask
  task automatic loss_indicator_output(logic f, logic s, logic e);
    @(posedge clk);
    signal_loss_flag <= f;
    frame_sync <= s;
    settle(2);
    chk("loss", 8'(loss_indicator_output_q), 8'(e));
  endtask
  task automatic step;
    @(posedge clk);
    seq_step <= 1'b1;
    @(posedge clk);
    seq_step <= 1'b0;
    settle(1);
  endtask
  task automatic path(logic [7:0] d, logic t, logic r);
    wr(EJC_ADDR_JA, d);
    settle(2);
    chk("on_tx", 8'(ja_on_tx_q), 8'(t));
    chk("on_rx", 8'(ja_on_rx_q), 8'(r));
  endtask
  // Alternating bits so a short or long FIFO shows up in the popped order
  task automatic push(int n);
    for (int k = 0; k < n; k++) begin
      @(posedge clk);
      ja_wr_valid <= 1'b1;
      ja_wr_bit <= k[0];
    end
    @(posedge clk);
    ja_wr_valid <= 1'b0;
  endtask
  task automatic pop;
    @(posedge clk);
    ja_rd_valid <= 1'b1;
    @(posedge clk);
    ja_rd_valid <= 1'b0;
    @(negedge clk);
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // ==========================================================
  // Watchdog, well beyond the few thousand cycles the tests need
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    end_sim();
  end

  // ==========================================================
  // Test sequence
  initial begin
    repeat (20) @(posedge clk);
    @(negedge clk);
    chk("empty", 8'(ja_empty_q), 8'h01);
    @(posedge clk);
    rst_n <= 1'b1;
    rd_chk("acc", EJC_ADDR_ACCESS, 8'h00);
    rd_chk("ja", EJC_ADDR_JA, 8'h00);
    // Unused bits, other address, other page
    wr(EJC_ADDR_ACCESS, 8'hFF);
    wr(EJC_ADDR_JA, 8'hFF);
    rd_chk("acc", EJC_ADDR_ACCESS, 8'h07);
    rd_chk("ja", EJC_ADDR_JA, 8'hFE);
    chk("fp_fmt", 8'(frame_pulse_format_q), 8'h01);
    rd_chk("unmapped", 5'h14, 8'h00);
    @(posedge clk);
    reg_page <= 8'h03;
    rd_chk("page", EJC_ADDR_ACCESS, 8'h00);
    @(posedge clk);
    reg_page <= 8'h02;
    // Loss indicator sources
    wr(EJC_ADDR_ACCESS, 8'h00);
    settle(1);
    chk("fp_fmt", 8'(frame_pulse_format_q), 8'h00);
    loss_indicator_output(1'b0, 1'b0, 1'b1);
    loss_indicator_output(1'b1, 1'b1, 1'b1);
    loss_indicator_output(1'b0, 1'b1, 1'b0);
    wr(EJC_ADDR_ACCESS, 8'h04);
    loss_indicator_output(1'b1, 1'b1, 1'b1);
    loss_indicator_output(1'b0, 1'b0, 1'b0);
    loss_indicator_output(1'b0, 1'b1, 1'b0);
    // Slot tests off: data passes unchanged
    chk("tx_pass", tx_pcm_q, 8'h5A);
    chk("rx_pass", rx_pcm_q, 8'hC3);
    // Milliwatt sequence on both paths
    wr(EJC_ADDR_ACCESS, 8'h02);
    @(posedge clk);
    tx_slot_test_enable <= 1'b1;
    rx_slot_test_enable <= 1'b1;
    settle(1);
    for (int i = 0; i < 8; i++) begin
      chk("tx_mw", tx_pcm_q, mw[i]);
      chk("rx_mw", rx_pcm_q, mw[i]);
      step();
    end
    // Steps above moved the generator too; a select write reseeds it
    wr(EJC_ADDR_ACCESS, 8'h02);
    wr(EJC_ADDR_ACCESS, 8'h00);
    settle(1);
    chk("tx_prbs", tx_pcm_q, 8'hFF);
    step();
    chk("tx_prbs", tx_pcm_q, 8'hFE);
    wr(EJC_ADDR_ACCESS, 8'h02);
    wr(EJC_ADDR_ACCESS, 8'h00);
    settle(1);
    chk("rx_prbs", rx_pcm_q, 8'hFF);
    // Attenuator placement; centre bit held so no re-centre half-fills the FIFO
    path(8'hE0, 1'b1, 1'b0);
    path(8'hA0, 1'b0, 1'b1);
    path(8'h60, 1'b0, 1'b0);
    push(4);
    settle(2);
    chk("empty", 8'(ja_empty_q), 8'h01);
    // Every depth code: fill past full, drain exactly the depth
    for (int c = 0; c < 8; c++) begin
      wr(EJC_ADDR_JA, 8'h82 | 8'(c << 2));
      wr(EJC_ADDR_JA, 8'h80 | 8'(c << 2));
      push(16 * (c + 1) + 4);
      for (int k = 0; k < 16 * (c + 1); k++) begin
        pop();
        chk("bit", 8'(ja_rd_bit_q), 8'(k % 2));
      end
      settle(1);
      chk("empty", 8'(ja_empty_q), 8'h01);
    end
    // Clear empties a part-filled FIFO
    push(4);
    settle(2);
    chk("empty", 8'(ja_empty_q), 8'h00);
    wr(EJC_ADDR_JA, 8'h9E);
    settle(2);
    chk("empty", 8'(ja_empty_q), 8'h01);
    // Centre toggle opens a bounded window and half-fills the FIFO
    wr(EJC_ADDR_JA, 8'hA0);
    settle(3);
    chk("centring", 8'(ja_centring_q), 8'h01);
    chk("empty", 8'(ja_empty_q), 8'h00);
    settle(14);
    chk("centring", 8'(ja_centring_q), 8'h01);
    settle(1);
    chk("centring", 8'(ja_centring_q), 8'h00);
    end_sim();
  end
endmodule
